// >>> hdl/rcc_pkg.sv
// package: constants and carrier types of the command classifier
package rcc_pkg;

    // -------------------------------------------------------------
    // command word fields
    // -------------------------------------------------------------
    localparam int ADDR_POS  = 11;
    localparam int DIR_POS   = 10;
    localparam int SUB_POS   = 5;
    localparam int COUNT_POS = 0;
    localparam logic [4:0] BROADCAST_TERMINAL_ADDRESS = 5'h1F;
    localparam logic [4:0] MODE_SUB_LOW  = 5'h00;
    localparam logic [4:0] MODE_SUB_HIGH = 5'h1F;
    localparam logic [4:0] MODE_CODE_SIXTEEN = 5'h10;

    // -------------------------------------------------------------
    // interrupt flag positions and reset values
    // -------------------------------------------------------------
    localparam int BROADCAST_FLAG_POS  = 5;
    localparam int MSG_ERROR_FLAG_POS  = 4;
    localparam int ACCESSED_FLAG_POS   = 3;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] ILLEGAL_RESET = 16'h0000;

    // -------------------------------------------------------------
    // illegalization table window and mode data base in shared ram
    // -------------------------------------------------------------
    localparam logic [15:0] ILLEGAL_BASE = 16'h0200;
    localparam logic [15:0] ILLEGAL_LAST = 16'h02FF;
    localparam logic [15:0] MODE_DATA_BASE = 16'h0400;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic       sync_ok;
        logic       manchester_ok;
        logic       count_ok;
        logic       parity;
        logic       command_sync;
        logic [15:0] data;
    } rcc_rx_word_t;

    typedef struct packed {
        logic [4:0] address;
        logic       transmit;
        logic [4:0] subaddress_field;
        logic [4:0] count;
    } rcc_command_t;

    typedef struct packed {
        logic       respond;
        logic       message_error;
        logic       mode;
        logic       broadcast;
        logic       undefined_mode;
        logic       reserved_mode;
        logic       data_receive;
        logic       data_transmit;
        logic [5:0] word_count;
        logic [15:0] mode_data_addr;
    } rcc_result_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_FETCH  = 4'b0010,
        ST_WAIT   = 4'b0100,
        ST_DECIDE = 4'b1000
    } rcc_state_t;

endpackage

// >>> hdl/rcc_classifier.sv
// command validation and classification for a serial-bus remote terminal
//
// Summary of operation
// - broadcast enabled and valid command to address 31 sets flag bit 5
// - message error status during valid message sets flag bit 4
// - valid command with access interrupt in its descriptor sets flag bit 3
// - flag bits 2 to 0 ignore writes and read zero
// - word valid only with good sync, encoding, bit count and odd parity
// - valid command word keeps only its 16 data bits
// - command splits into address, direction, subaddress, count or mode code
// - addressed when address matches latched address; broadcast when it is 31
// - broadcast-invalid set makes address 31 commands invalid, ignored silently
// - subaddress 1 to 30 is data transfer of 1 to 32 words, 0 means 32
// - subaddress 0 or 31 is a mode command with a mode code
// - mode codes 16 to 31 carry one data word, direction set by bit
// - mode codes 0 to 15 carry no data, need direction 1
// - exactly 22 undefined mode combinations
// - undefined-mode-invalid set: undefined modes ignored, no status update
// - undefined-mode-invalid resets to 0, undefined modes use the lookup
// - legal undefined mode: clear status, data word for 17,20,21 transmit
// - illegal command: status with message error only, no data word
// - 27 reserved mode combinations follow their own table entry
// - table entries zero after reset, so all commands respond in form
// - subaddress commands use host descriptor data pointers
// - mode data words go to a fixed location per mode code
// - one illegal bit fetched per valid command; 1 illegal, 0 legal
// - illegal bits live in words 0x0200 to 0x02FF by quadrant and subaddress
`timescale 1ns/1ps

module rcc_classifier
    import rcc_pkg::*;
(
    input  wire logic         i_clock,
    input  wire logic         i_resetn,
    input  wire rcc_rx_word_t i_rx_word,
    input  wire logic         i_rx_valid,
    input  wire logic [4:0]   i_terminal_address,
    input  wire logic         i_broadcast_invalid_bit,
    input  wire logic         i_undefined_mode_invalid_bit,
    input  wire logic [15:0]  i_ram_rdata,
    input  wire logic         i_ram_rvalid,
    input  wire logic         i_descriptor_access_irq,
    input  wire logic         i_message_error_event,
    input  wire logic [15:0]  i_flag_enable,
    input  wire logic         i_flag_clear,
    output logic              o_ram_read,
    output logic [15:0]       o_ram_addr,
    output logic              o_busy,
    output logic              o_result_valid,
    output rcc_result_t       o_result,
    output logic [15:0]       o_flags,
    output logic              o_pending
);

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    function automatic logic is_mode_sub(input logic [4:0] sub);
        return (sub == MODE_SUB_LOW) || (sub == MODE_SUB_HIGH);
    endfunction

    function automatic logic is_undefined(input logic [4:0] code, input logic tx);
        if (!tx) begin
            return (code < MODE_CODE_SIXTEEN) || (code == 5'h10)
                || (code == 5'h12) || (code == 5'h13);
        end
        return (code == 5'h11) || (code == 5'h14) || (code == 5'h15);
    endfunction

    function automatic logic is_reserved(input logic [4:0] code, input logic tx);
        return (code >= 5'h16) || (tx && code >= 5'h09 && code <= 5'h0F);
    endfunction

    // ---------------------------------------------------------------
    // word acceptance and field split
    // ---------------------------------------------------------------
    logic         word_ok;
    rcc_command_t cmd_in;
    logic         addressed_in;
    logic         bcast_in;
    logic         mode_in;
    logic         undef_in;
    logic         accept_in;

    assign word_ok = i_rx_valid && i_rx_word.command_sync && i_rx_word.sync_ok
        && i_rx_word.manchester_ok && i_rx_word.count_ok
        && ((^i_rx_word.data) ^ i_rx_word.parity);
    assign cmd_in.address          = i_rx_word.data[ADDR_POS +: 5];
    assign cmd_in.transmit         = i_rx_word.data[DIR_POS];
    assign cmd_in.subaddress_field = i_rx_word.data[SUB_POS +: 5];
    assign cmd_in.count            = i_rx_word.data[COUNT_POS +: 5];
    assign addressed_in = cmd_in.address == i_terminal_address;
    assign bcast_in     = (cmd_in.address == BROADCAST_TERMINAL_ADDRESS)
        && !i_broadcast_invalid_bit;
    assign mode_in  = is_mode_sub(cmd_in.subaddress_field);
    assign undef_in = mode_in && is_undefined(cmd_in.count, cmd_in.transmit);
    // broadcast transmit to a data subaddress has no meaning on the bus
    assign accept_in = word_ok && (addressed_in || bcast_in)
        && !(undef_in && i_undefined_mode_invalid_bit)
        && !(bcast_in && !addressed_in && cmd_in.transmit && !mode_in);

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    rcc_state_t   state;
    rcc_state_t   next_state;
    rcc_command_t cmd;
    logic         cmd_bcast;
    logic [15:0]  illegal_word;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:   if (word_ok && accept_in) next_state = ST_FETCH;
            ST_FETCH:  next_state = ST_WAIT;
            ST_WAIT:   if (i_ram_rvalid) next_state = ST_DECIDE;
            ST_DECIDE: next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd       <= '0;
            cmd_bcast <= 1'b0;
        end else if (state == ST_IDLE && accept_in) begin
            cmd       <= cmd_in;
            cmd_bcast <= bcast_in && !addressed_in;
        end
    end

    // ---------------------------------------------------------------
    // illegalization fetch
    // ---------------------------------------------------------------
    // quadrant: {broadcast, transmit}; word pair per subaddress, odd word
    // holds counts or codes 16 to 31
    logic [15:0] table_addr;
    assign table_addr = ILLEGAL_BASE | {8'h00, cmd_bcast, cmd.transmit,
        cmd.subaddress_field, cmd.count[4]};

    assign o_ram_read = state == ST_FETCH;
    assign o_ram_addr = table_addr;
    assign o_busy     = state != ST_IDLE;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            illegal_word <= ILLEGAL_RESET;
        end else if (state == ST_WAIT && i_ram_rvalid) begin
            illegal_word <= i_ram_rdata;
        end
    end

    // ---------------------------------------------------------------
    // response decision
    // ---------------------------------------------------------------
    logic        illegal;
    logic        cmd_mode;
    logic        cmd_undef;
    logic        with_data;
    rcc_result_t next_result;

    assign illegal   = illegal_word[cmd.count[3:0]];
    assign cmd_mode  = is_mode_sub(cmd.subaddress_field);
    assign cmd_undef = cmd_mode && is_undefined(cmd.count, cmd.transmit);
    // undefined codes 16,18,19 with receive have no data word
    assign with_data = cmd_mode && cmd.count >= MODE_CODE_SIXTEEN
        && !(cmd_undef && !cmd.transmit);

    always_comb begin
        next_result                = '0;
        next_result.respond        = !cmd_bcast;
        next_result.message_error  = illegal;
        next_result.mode           = cmd_mode;
        next_result.broadcast      = cmd_bcast;
        next_result.undefined_mode = cmd_undef;
        next_result.reserved_mode  = cmd_mode && is_reserved(cmd.count, cmd.transmit);
        if (cmd_mode) begin
            next_result.data_receive   = with_data && !cmd.transmit;
            next_result.data_transmit  = with_data && cmd.transmit && !illegal;
            next_result.word_count     = with_data ? 6'h01 : 6'h00;
            next_result.mode_data_addr = MODE_DATA_BASE
                | {10'h000, cmd.transmit, cmd.count};
        end else begin
            next_result.data_receive  = !cmd.transmit;
            next_result.data_transmit = cmd.transmit && !illegal;
            next_result.word_count    = (cmd.count == 5'h00) ? 6'h20 : {1'b0, cmd.count};
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_result       <= '0;
            o_result_valid <= 1'b0;
        end else begin
            o_result_valid <= state == ST_DECIDE;
            if (state == ST_DECIDE) begin
                o_result <= next_result;
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt flags
    // ---------------------------------------------------------------
    // set beats clear so an event in the clearing cycle is kept
    logic [15:0] flag_set;
    always_comb begin
        flag_set = 16'h0000;
        flag_set[BROADCAST_FLAG_POS] = state == ST_DECIDE && cmd_bcast;
        flag_set[MSG_ERROR_FLAG_POS] = i_message_error_event;
        flag_set[ACCESSED_FLAG_POS]  = state == ST_DECIDE && i_descriptor_access_irq;
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_flags <= FLAGS_RESET;
        end else begin
            o_flags <= ((i_flag_clear ? 16'h0000 : o_flags) | flag_set) & 16'h0038;
        end
    end

    assign o_pending = |(o_flags & i_flag_enable);

endmodule

// >>> verification/rcc_classifier_chk.sv
// checker: port properties of the command classifier
`timescale 1ns/1ps
module rcc_classifier_chk
    import rcc_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_resetn,
    input wire logic        i_ram_rvalid,
    input wire logic        i_message_error_event,
    input wire logic [15:0] i_flag_enable,
    input wire logic        o_ram_read,
    input wire logic [15:0] o_ram_addr,
    input wire logic        o_busy,
    input wire logic        o_result_valid,
    input wire rcc_result_t o_result,
    input wire logic [15:0] o_flags,
    input wire logic        o_pending
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    chk_table_window: assert property (o_ram_read |-> o_ram_addr[15:8] == 8'h02)
        else $error("table read outside window");
    chk_low_zero: assert property (o_flags[2:0] == 3'h0)
        else $error("low flag bits set");
    chk_pending_mask: assert property (o_pending == |(o_flags & i_flag_enable))
        else $error("pending not masked flags");
    chk_result_time: assert property (i_ram_rvalid && o_busy |-> ##2 o_result_valid)
        else $error("result late");
    chk_one_fetch: assert property (o_ram_read |=> !o_ram_read [*2])
        else $error("second fetch");
    chk_illegal_quiet: assert property (o_result_valid && o_result.message_error |-> !o_result.data_transmit)
        else $error("data word on illegal");
    chk_mode_store: assert property (o_result_valid && o_result.mode |-> o_result.mode_data_addr[15:6] == 10'h010)
        else $error("mode store outside range");
    chk_bcast_flag: assert property (o_result_valid && o_result.broadcast |-> o_flags[5])
        else $error("broadcast flag missing");
    chk_message_error_flag_flag: assert property (i_message_error_event |=> o_flags[4])
        else $error("message error flag missing");
    chk_count_range: assert property (o_result_valid && o_result.data_receive && !o_result.mode
        |-> o_result.word_count inside {[1:32]})
        else $error("word count out of range");
    cover property (o_result_valid && o_result.mode);
    cover property (o_result_valid && o_result.message_error);
    cover property (o_result_valid && o_result.broadcast);
endmodule

// >>> verification/rcc_table_model.sv
// partner: shared ram holding the illegal-command table
`timescale 1ns/1ps
module rcc_table_model (
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_read,
    input  wire logic [15:0] i_addr,
    input  wire logic [1:0]  i_delay,
    input  wire logic        i_write,
    input  wire logic [7:0]  i_waddr,
    input  wire logic [15:0] i_wdata,
    output logic             o_rvalid,
    output logic [15:0]      o_rdata
);
    logic [15:0] mem [256];
    logic [15:0] word;
    logic [1:0]  cnt;
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            foreach (mem[k]) mem[k] <= 16'h0000;
            cnt <= 2'h0;
            o_rvalid <= 1'b0;
            o_rdata <= 16'hA5A5;
        end else begin
            o_rvalid <= 1'b0;
            o_rdata <= ~o_rdata; // idle data keeps moving, never a stale match
            if (i_write) mem[i_waddr] <= i_wdata;
            if (i_read) begin
                word <= mem[i_addr[7:0]];
                cnt <= i_delay;
                o_rvalid <= (i_delay == 2'h0);
                if (i_delay == 2'h0) o_rdata <= mem[i_addr[7:0]];
            end else if (cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
                o_rvalid <= (cnt == 2'h1);
                if (cnt == 2'h1) o_rdata <= word;
            end
        end
    end
endmodule

// >>> verification/rt_command_classifier_bench.sv
// testbench: command classification sequences
`timescale 1ns/1ps
module rt_command_classifier_bench
    import rcc_pkg::*;
;
    logic clk = 1'b0, rst_n, rxv, bi, ui, acc, mee, fcl, rd, rv, busy, res_v, pend, wr, t;
    logic [4:0] ta, c;
    logic [15:0] fen, ra, rdat, flg, wd;
    logic [7:0] wa;
    logic [1:0] dly;
    rcc_rx_word_t rxw;
    rcc_result_t res;
    int failures = 0, tests_run = 0, k, nu, nr;
    always #20 clk = ~clk;
    rcc_classifier dut_u (.i_clock(clk), .i_resetn(rst_n), .i_rx_word(rxw), .i_rx_valid(rxv),
        .i_terminal_address(ta), .i_broadcast_invalid_bit(bi), .i_undefined_mode_invalid_bit(ui),
        .i_ram_rdata(rdat), .i_ram_rvalid(rv), .i_descriptor_access_irq(acc), .i_message_error_event(mee),
        .i_flag_enable(fen), .i_flag_clear(fcl), .o_ram_read(rd), .o_ram_addr(ra), .o_busy(busy),
        .o_result_valid(res_v), .o_result(res), .o_flags(flg), .o_pending(pend));
    rcc_table_model ram_u (.i_clock(clk), .i_resetn(rst_n), .i_read(rd), .i_addr(ra), .i_delay(dly),
        .i_write(wr), .i_waddr(wa), .i_wdata(wd), .o_rvalid(rv), .o_rdata(rdat));
    task automatic check(input string nm, input logic [15:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // err flips validity bits; ex is respond,error,mode,undefined,reserved
    task automatic cmd(input logic [15:0] w, input logic [4:0] err, input logic tk, input logic [4:0] ex);
        int n;
        @(posedge clk);
        rxw <= {{3'b111, ~^w, 1'b1} ^ err, w};
        rxv <= 1'b1;
        @(posedge clk);
        rxv <= 1'b0;
        for (n = 0; n < 10 && res_v !== 1'b1; n++) @(negedge clk);
        check("taken", 16'(res_v), 16'(tk));
        if (tk) check("class", 16'({res.respond, res.message_error, res.mode, res.undefined_mode,
            res.reserved_mode}), 16'(ex));
    endtask
    task automatic tbl(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1; wa <= a; wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    function automatic logic [15:0] cw(input logic [4:0] a, input logic tr, input logic [4:0] s, n);
        return {a, tr, s, n};
    endfunction
    initial begin
        rst_n = 1'b0; rxv = 1'b0; rxw = '0; ta = 5'h05; bi = 1'b0; ui = 1'b0; acc = 1'b0; mee = 1'b0;
        fen = 16'h0000; fcl = 1'b0; wr = 1'b0; wa = 8'h00; wd = 16'h0000; dly = 2'h0; nu = 0; nr = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        check("flags", flg, 16'h0000);
        cmd(cw(5'h05, 1'b0, 5'h03, 5'h00), 5'h00, 1'b1, 5'h10);
        check("count", 16'(res.word_count), 16'h0020);
        check("recv", 16'({res.data_receive, res.data_transmit}), 16'h0002);
        cmd(cw(5'h06, 1'b0, 5'h03, 5'h00), 5'h00, 1'b0, 5'h00);
        for (k = 0; k < 5; k++) cmd(cw(5'h05, 1'b0, 5'h03, 5'h01), 5'(5'h10 >> k), 1'b0, 5'h00);
        $display("end validity");
        for (k = 0; k < 64; k++) begin
            t = k[5]; c = k[4:0];
            cmd(cw(5'h05, t, k[0] ? 5'h1F : 5'h00, c), 5'h00, 1'b1,
                {3'b101, t ? (c == 17 || c == 20 || c == 21) : (c <= 19 && c != 17),
                c >= 22 || (t && c >= 9 && c <= 15)});
            check("store", res.mode_data_addr, 16'h0400 | 16'({t, c}));
            // undefined receive codes 16, 18 and 19 carry no data word
            check("dir", 16'({res.data_receive, res.data_transmit}),
                16'({!t && c[4] && c != 16 && c != 18 && c != 19, t && c[4]}));
            nu += res.undefined_mode;
            nr += res.reserved_mode;
        end
        check("undefined", 16'(nu), 16'd22);
        check("reserved", 16'(nr), 16'd27);
        $display("end modes");
        @(posedge clk) ui <= 1'b1;
        cmd(cw(5'h05, 1'b0, 5'h00, 5'h02), 5'h00, 1'b0, 5'h00);
        cmd(cw(5'h05, 1'b1, 5'h00, 5'h02), 5'h00, 1'b1, 5'h14);
        @(posedge clk) ui <= 1'b0;
        dly <= 2'h2; // slow table answers
        tbl(8'h06, 16'h0001);
        cmd(cw(5'h05, 1'b0, 5'h03, 5'h00), 5'h00, 1'b1, 5'h18);
        tbl(8'h41, 16'h0002);
        cmd(cw(5'h05, 1'b1, 5'h00, 5'h11), 5'h00, 1'b1, 5'h1E);
        check("illegal tx", 16'(res.data_transmit), 16'h0000);
        dly <= 2'h0;
        $display("end illegal");
        fen <= 16'h0038;
        cmd(cw(5'h1F, 1'b0, 5'h03, 5'h02), 5'h00, 1'b1, 5'h00);
        check("bcast", flg, 16'h0020);
        check("pend", 16'(pend), 16'h0001);
        @(posedge clk) fcl <= 1'b1;
        @(posedge clk) fcl <= 1'b0;
        @(negedge clk) check("clear", flg, 16'h0000);
        @(posedge clk) bi <= 1'b1;
        cmd(cw(5'h1F, 1'b0, 5'h03, 5'h02), 5'h00, 1'b0, 5'h00);
        @(posedge clk) bi <= 1'b0;
        acc <= 1'b1;
        cmd(cw(5'h05, 1'b1, 5'h03, 5'h04), 5'h00, 1'b1, 5'h10);
        check("access", flg, 16'h0008);
        @(posedge clk) acc <= 1'b0;
        fen <= 16'h0000; mee <= 1'b1;
        @(posedge clk) mee <= 1'b0;
        @(negedge clk) check("message_error_flag", flg, 16'h0018);
        check("masked", 16'(pend), 16'h0000);
        $display("end flags");
        report_and_stop();
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule
bind rcc_classifier rcc_classifier_chk chk_u (.i_clock(i_clock), .i_resetn(i_resetn), .i_ram_rvalid(i_ram_rvalid),
    .i_message_error_event(i_message_error_event), .i_flag_enable(i_flag_enable), .o_ram_read(o_ram_read),
    .o_ram_addr(o_ram_addr), .o_busy(o_busy), .o_result_valid(o_result_valid), .o_result(o_result),
    .o_flags(o_flags), .o_pending(o_pending));
